/* File: hw/atoc_timer.sv */
// holds the top of the 8-bit timer: APB registers, counter unit and compare unit
// assumes an APB master on clk; pin direction bit and port value come from the port logic
`timescale 1ns/1ps
`default_nettype none
module atoc_timer (
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output var  logic [31:0] prdata,
	output var  logic        pready,
	output var  logic        pslverr,
	input  wire logic        crystal_pin_one,
	input  wire logic        irq_ack_overflow,
	input  wire logic        irq_ack_compare,
	input  wire logic        port_value,
	input  wire logic        port_dir_out,
	output var  logic        overflow_irq_q,
	output var  logic        compare_irq_q,
	output var  logic        pin_out_q,
	output var  logic        pin_oe_n_q
);
	// ----------------------------------------
	// state
	// ----------------------------------------
	atoc_pkg::atoc_ctrl_t ctrl_q;
	logic [7:0]  count_value_q;
	logic [7:0]  compare_active_q;
	logic [7:0]  compare_buffer_q;
	logic        overflow_flag_q;
	logic        compare_match_flag_q;
	logic        overflow_irq_enable_q;
	logic        compare_irq_enable_q;
	logic        async_clock_select_q;
	logic        block_q;
	logic        count_down_q;
	logic        compare_output_q;
	logic        timer_tick;

	// ----------------------------------------
	// bus decode
	// ----------------------------------------
	// one wait state so that read data leaves a flip-flop
	logic access;
	logic done;
	logic wr;
	logic mapped;
	logic wr_ctrl;
	logic wr_count;
	logic wr_compare;
	logic wr_flags;
	logic force_ev;
	logic force_q;
	atoc_pkg::atoc_wgm_t wgm_wr;
	assign access = psel & penable;
	assign done   = access & pready;
	assign wr     = done & pwrite;
	assign mapped = (paddr == atoc_pkg::ADDR_CONTROL) || (paddr == atoc_pkg::ADDR_COUNT) ||
		(paddr == atoc_pkg::ADDR_COMPARE) || (paddr == atoc_pkg::ADDR_FLAGS) ||
		(paddr == atoc_pkg::ADDR_MASK) || (paddr == atoc_pkg::ADDR_ASYNC);
	assign wr_ctrl    = wr && paddr == atoc_pkg::ADDR_CONTROL;
	assign wr_count   = wr && paddr == atoc_pkg::ADDR_COUNT;
	assign wr_compare = wr && paddr == atoc_pkg::ADDR_COMPARE;
	assign wr_flags   = wr && paddr == atoc_pkg::ADDR_FLAGS;

	logic buffered;
	logic pwm_mode;
	// both PWM modes share buffering and the refusal of a forced compare
	function automatic logic is_pwm(input atoc_pkg::atoc_wgm_t m);
		return (m == atoc_pkg::ATOC_WGM_PHASE) || (m == atoc_pkg::ATOC_WGM_FAST);
	endfunction : is_pwm
	assign pwm_mode = is_pwm(ctrl_q.wgm);
	assign buffered = pwm_mode;
	assign wgm_wr   = atoc_pkg::atoc_wgm_t'(pwdata[atoc_pkg::CTRL_WGM_LSB +: 2]);
	// force is a write-only strobe, honoured in the non-PWM modes only;
	// it waits one cycle so that it acts with the mode bits written beside it,
	// and a force written together with a PWM mode is dropped, not deferred
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			force_q <= 1'b0;
		end else begin
			force_q <= wr_ctrl && pwdata[atoc_pkg::CTRL_FORCE_BIT] && !is_pwm(wgm_wr);
		end
	end
	assign force_ev = force_q;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			pready <= 1'b0;
		end else begin
			pready <= access & ~pready;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			prdata  <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else if (access && !pready) begin
			pslverr <= ~mapped;
			prdata  <= 32'h0000_0000;
			if (!pwrite) begin
				unique case (paddr)
					atoc_pkg::ADDR_CONTROL: prdata <= {25'h0, ctrl_q};
					atoc_pkg::ADDR_COUNT:   prdata <= {24'h0, count_value_q};
					atoc_pkg::ADDR_COMPARE: prdata <= {24'h0,
						buffered ? compare_buffer_q : compare_active_q};
					atoc_pkg::ADDR_FLAGS:   prdata <= {30'h0, compare_match_flag_q, overflow_flag_q};
					atoc_pkg::ADDR_MASK:    prdata <= {30'h0, compare_irq_enable_q,
						overflow_irq_enable_q};
					atoc_pkg::ADDR_ASYNC:   prdata <= {31'h0, async_clock_select_q};
					default:                prdata <= 32'h0000_0000;
				endcase
			end
		end
	end

	// ----------------------------------------
	// configuration registers
	// ----------------------------------------
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ctrl_q <= atoc_pkg::CTRL_RESET;
		end else if (wr_ctrl) begin
			ctrl_q <= atoc_pkg::atoc_ctrl_t'(pwdata[atoc_pkg::CTRL_FORCE_BIT-1:0]);
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			overflow_irq_enable_q <= 1'b0;
			compare_irq_enable_q  <= 1'b0;
		end else if (wr && paddr == atoc_pkg::ADDR_MASK) begin
			overflow_irq_enable_q <= pwdata[atoc_pkg::FLAG_OVF_BIT];
			compare_irq_enable_q  <= pwdata[atoc_pkg::FLAG_CMP_BIT];
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			async_clock_select_q <= 1'b0;
		end else if (wr && paddr == atoc_pkg::ADDR_ASYNC) begin
			async_clock_select_q <= pwdata[atoc_pkg::ASYNC_SEL_BIT];
		end
	end

	// ----------------------------------------
	// clock source
	// ----------------------------------------
	atoc_tick_gen u_tick (
		.clk                (clk),
		.rst                (rst),
		.async_clock_select (async_clock_select_q),
		.clock_select_field (ctrl_q.cs),
		.crystal_pin_one    (crystal_pin_one),
		.timer_tick_q       (timer_tick)
	);

	// ----------------------------------------
	// counter unit
	// ----------------------------------------
	logic at_max;
	logic at_bottom;
	logic at_compare;
	logic match_ev;
	logic overflow_ev;
	logic bottom_ev;
	logic top_reached;
	assign at_max     = count_value_q == atoc_pkg::CNT_MAX;
	assign at_bottom  = count_value_q == atoc_pkg::CNT_BOTTOM;
	assign at_compare = count_value_q == compare_active_q;
	// top is the compare value only in clear-on-match mode
	assign top_reached = (ctrl_q.wgm == atoc_pkg::ATOC_WGM_CTC) ? at_compare : at_max;
	// a match is judged on the tick after equality; the count write also blocks its own tick
	assign match_ev = timer_tick && at_compare && !block_q && !wr_count;
	// counter becomes zero from max, or turns at bottom in phase correct mode
	assign overflow_ev = timer_tick && !wr_count && ((ctrl_q.wgm == atoc_pkg::ATOC_WGM_PHASE) ?
		(count_down_q && at_bottom) : at_max);
	assign bottom_ev = timer_tick && !wr_count && ctrl_q.wgm == atoc_pkg::ATOC_WGM_FAST && at_max;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			count_value_q <= atoc_pkg::RST_BYTE;
		end else if (wr_count) begin
			count_value_q <= pwdata[7:0];
		end else if (timer_tick) begin
			unique case (ctrl_q.wgm)
				atoc_pkg::ATOC_WGM_CTC:
					count_value_q <= at_compare ? atoc_pkg::CNT_BOTTOM
						: count_value_q + 8'h01;
				atoc_pkg::ATOC_WGM_PHASE:
					if (count_down_q ? !at_bottom : at_max)
						count_value_q <= count_value_q - 8'h01;
					else
						count_value_q <= count_value_q + 8'h01;
				default:
					count_value_q <= count_value_q + 8'h01;
			endcase
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			count_down_q <= 1'b0;
		end else if (ctrl_q.wgm != atoc_pkg::ATOC_WGM_PHASE) begin
			count_down_q <= 1'b0;
		end else if (timer_tick && !wr_count) begin
			if (at_max)
				count_down_q <= 1'b1;
			else if (at_bottom)
				count_down_q <= 1'b0;
		end
	end

	// block lasts until the next tick, so a stopped timer keeps it indefinitely
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			block_q <= 1'b0;
		end else if (wr_count) begin
			block_q <= 1'b1;
		end else if (timer_tick) begin
			block_q <= 1'b0;
		end
	end

	// ----------------------------------------
	// compare value and its buffer
	// ----------------------------------------
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			compare_buffer_q <= atoc_pkg::RST_BYTE;
		end else if (wr_compare) begin
			compare_buffer_q <= pwdata[7:0];
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			compare_active_q <= atoc_pkg::RST_BYTE;
		end else if (!buffered) begin
			if (wr_compare)
				compare_active_q <= pwdata[7:0];
		end else if (timer_tick && !wr_count && top_reached) begin
			// loading at max means fast mode wraps and phase mode turns with the new value
			compare_active_q <= compare_buffer_q;
		end
	end

	// ----------------------------------------
	// flags and interrupt requests
	// ----------------------------------------
	// a set in the same cycle as a clear wins
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			overflow_flag_q <= 1'b0;
		end else if (overflow_ev) begin
			overflow_flag_q <= 1'b1;
		end else if (irq_ack_overflow || (wr_flags && pwdata[atoc_pkg::FLAG_OVF_BIT])) begin
			overflow_flag_q <= 1'b0;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			compare_match_flag_q <= 1'b0;
		end else if (match_ev) begin
			compare_match_flag_q <= 1'b1;
		end else if (irq_ack_compare || (wr_flags && pwdata[atoc_pkg::FLAG_CMP_BIT])) begin
			compare_match_flag_q <= 1'b0;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			overflow_irq_q <= 1'b0;
			compare_irq_q  <= 1'b0;
		end else begin
			overflow_irq_q <= overflow_flag_q & overflow_irq_enable_q;
			compare_irq_q  <= compare_match_flag_q & compare_irq_enable_q;
		end
	end

	// ----------------------------------------
	// compare output and pin
	// ----------------------------------------
	atoc_wavegen u_wave (
		.clk              (clk),
		.rst              (rst),
		.match_ev         (match_ev),
		.bottom_ev        (bottom_ev),
		.force_ev         (force_ev),
		.count_down       (count_down_q),
		.wgm              (ctrl_q.wgm),
		.com              (ctrl_q.com),
		.compare_output_q (compare_output_q)
	);

	// direction stays with the port logic; only the value is overridden
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			pin_out_q  <= 1'b0;
			pin_oe_n_q <= 1'b1;
		end else begin
			pin_out_q  <= (ctrl_q.com != atoc_pkg::ATOC_COM_NONE) ? compare_output_q
				: port_value;
			pin_oe_n_q <= ~port_dir_out;
		end
	end
endmodule : atoc_timer
`default_nettype wire

/* File: hw/atoc_pkg.sv */
// holds constants, modes and carrier types of the 8-bit timer with one compare channel
// assumes a 32-bit APB slave port and one 100 MHz system clock
package atoc_pkg;
	// ----------------------------------------
	// register map (word aligned byte addresses)
	// ----------------------------------------
	localparam logic [7:0] ADDR_CONTROL = 8'h00;
	localparam logic [7:0] ADDR_COUNT   = 8'h04;
	localparam logic [7:0] ADDR_COMPARE = 8'h08;
	localparam logic [7:0] ADDR_FLAGS   = 8'h0C;
	localparam logic [7:0] ADDR_MASK    = 8'h10;
	localparam logic [7:0] ADDR_ASYNC   = 8'h14;
	// ----------------------------------------
	// field positions
	// ----------------------------------------
	localparam int CTRL_CS_LSB    = 0;
	localparam int CTRL_WGM_LSB   = 3;
	localparam int CTRL_COM_LSB   = 5;
	localparam int CTRL_FORCE_BIT = 7;
	localparam int FLAG_OVF_BIT   = 0;
	localparam int FLAG_CMP_BIT   = 1;
	localparam int ASYNC_SEL_BIT  = 0;
	// ----------------------------------------
	// values
	// ----------------------------------------
	localparam logic [7:0] CNT_BOTTOM    = 8'h00;
	localparam logic [7:0] CNT_MAX       = 8'hFF;
	localparam logic [7:0] RST_BYTE      = 8'h00;
	localparam logic [2:0] CS_STOPPED    = 3'h0;
	localparam int         PRESCALE_BITS = 10;
	typedef enum logic [1:0] {
		ATOC_WGM_NORMAL = 2'h0,
		ATOC_WGM_PHASE  = 2'h1,
		ATOC_WGM_CTC    = 2'h2,
		ATOC_WGM_FAST   = 2'h3
	} atoc_wgm_t;
	typedef enum logic [1:0] {
		ATOC_COM_NONE   = 2'h0,
		ATOC_COM_TOGGLE = 2'h1,
		ATOC_COM_CLEAR  = 2'h2,
		ATOC_COM_SET    = 2'h3
	} atoc_com_t;
	typedef struct packed {
		atoc_com_t  com;
		atoc_wgm_t  wgm;
		logic [2:0] cs;
	} atoc_ctrl_t;
	localparam atoc_ctrl_t CTRL_RESET = '{com: ATOC_COM_NONE, wgm: ATOC_WGM_NORMAL, cs: CS_STOPPED};
endpackage : atoc_pkg

/* File: hw/atoc_tick_gen.sv */
// holds the timer clock source: crystal synchroniser, clock select and prescaler
// assumes the crystal oscillator output arrives as a slow asynchronous pin level
`timescale 1ns/1ps
`default_nettype none
module atoc_tick_gen (
	input  wire logic       clk,
	input  wire logic       rst,
	input  wire logic       async_clock_select,
	input  wire logic [2:0] clock_select_field,
	input  wire logic       crystal_pin_one,
	output var  logic       timer_tick_q
);
	// ----------------------------------------
	// crystal crossing
	// ----------------------------------------
	logic       xtal_meta_q;
	logic       xtal_sync_q;
	logic       xtal_last_q;
	logic       src_tick;
	logic [atoc_pkg::PRESCALE_BITS-1:0] pre_q;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			xtal_meta_q <= 1'b0;
			xtal_sync_q <= 1'b0;
			xtal_last_q <= 1'b0;
		end else begin
			xtal_meta_q <= crystal_pin_one;
			xtal_sync_q <= xtal_meta_q;
			xtal_last_q <= xtal_sync_q;
		end
	end

	// default source is the system clock, crystal edges when selected
	assign src_tick = async_clock_select ? (xtal_sync_q & ~xtal_last_q) : 1'b1;

	// ----------------------------------------
	// prescaler taps
	// ----------------------------------------
	// divide by two to the power (select minus one); stop code gives nothing
	function automatic logic tap_hit(input logic [2:0] cs, input logic [9:0] pre);
		logic [9:0] mask;
		mask = 10'h000;
		if (cs != atoc_pkg::CS_STOPPED)
			mask = 10'((11'h001 << (cs - 3'h1)) - 11'h001);
		tap_hit = (cs != atoc_pkg::CS_STOPPED) && ((pre & mask) == 10'h000);
	endfunction : tap_hit

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			pre_q <= '0;
		end else if (clock_select_field == atoc_pkg::CS_STOPPED) begin
			pre_q <= '0;
		end else if (src_tick) begin
			pre_q <= pre_q + 10'h001;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			timer_tick_q <= 1'b0;
		end else begin
			timer_tick_q <= src_tick & tap_hit(clock_select_field, pre_q);
		end
	end
endmodule : atoc_tick_gen
`default_nettype wire

/* File: hw/atoc_wavegen.sv */
// holds the compare output state and its set, clear and toggle actions
// assumes match and bottom strobes from the counter unit and the force strobe from the bus decode are one-cycle pulses
`timescale 1ns/1ps
`default_nettype none
module atoc_wavegen (
	input  wire logic                clk,
	input  wire logic                rst,
	input  wire logic                match_ev,
	input  wire logic                bottom_ev,
	input  wire logic                force_ev,
	input  wire logic                count_down,
	input  wire atoc_pkg::atoc_wgm_t wgm,
	input  wire atoc_pkg::atoc_com_t com,
	output var  logic                compare_output_q
);
	logic non_pwm;
	assign non_pwm = (wgm == atoc_pkg::ATOC_WGM_NORMAL) || (wgm == atoc_pkg::ATOC_WGM_CTC);

	// state is never reset by a mode change, only by these events
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			compare_output_q <= 1'b0;
		end else if (com == atoc_pkg::ATOC_COM_NONE) begin
			compare_output_q <= compare_output_q;
		end else if (non_pwm) begin
			if (match_ev || force_ev) begin
				unique case (com)
					atoc_pkg::ATOC_COM_TOGGLE: compare_output_q <= ~compare_output_q;
					atoc_pkg::ATOC_COM_CLEAR:  compare_output_q <= 1'b0;
					atoc_pkg::ATOC_COM_SET:    compare_output_q <= 1'b1;
					default:                   compare_output_q <= compare_output_q;
				endcase
			end
		end else if (com != atoc_pkg::ATOC_COM_TOGGLE) begin
			// inverted flavour when both mode bits are set
			if (match_ev) begin
				compare_output_q <= (com == atoc_pkg::ATOC_COM_SET) ^
					(wgm == atoc_pkg::ATOC_WGM_PHASE && count_down);
			end else if (bottom_ev) begin
				compare_output_q <= (com == atoc_pkg::ATOC_COM_CLEAR);
			end
		end
	end
endmodule : atoc_wavegen
`default_nettype wire

/* File: test/atoc_checker.sv */
// checker for the timer's bus answers, pin outputs and interrupt outputs
// assumes it is bound into every atoc_timer and sees only that module's ports
`timescale 1ns/1ps
`default_nettype none
module atoc_checker (
	input wire logic        clk,
	input wire logic        rst,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        crystal_pin_one,
	input wire logic        irq_ack_overflow,
	input wire logic        irq_ack_compare,
	input wire logic        port_value,
	input wire logic        port_dir_out,
	input wire logic        overflow_irq_q,
	input wire logic        compare_irq_q,
	input wire logic        pin_out_q,
	input wire logic        pin_oe_n_q
);
	// ----------------------------------------
	// mirrors of output mode and mask, taken at write completion
	// ----------------------------------------
	logic [1:0] com_q;
	logic [1:0] msk_q;
	logic       wr_done;
	logic       mapped;
	assign wr_done = psel && penable && pready && pwrite;
	assign mapped  = (paddr[1:0] == 2'h0) && (paddr <= atoc_pkg::ADDR_ASYNC);
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			com_q <= 2'h0;
		end else if (wr_done && paddr == atoc_pkg::ADDR_CONTROL) begin
			com_q <= pwdata[atoc_pkg::CTRL_COM_LSB +: 2];
		end
	end
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			msk_q <= 2'h0;
		end else if (wr_done && paddr == atoc_pkg::ADDR_MASK) begin
			msk_q <= pwdata[1:0];
		end
	end
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	// ----------------------------------------
	// properties
	// ----------------------------------------
	property p_rdy; psel && penable && !$past(penable) |-> !pready ##1 pready; endproperty
	a_rdy: assert property (p_rdy) else $error("pready not in second access cycle");
	property p_rdy1; pready |=> !pready; endproperty
	a_rdy1: assert property (p_rdy1) else $error("pready held two cycles");
	property p_err; psel && penable && pready && !mapped |-> pslverr; endproperty
	a_err: assert property (p_err) else $error("unmapped access not refused");
	property p_nerr; psel && penable && pready && mapped |-> !pslverr; endproperty
	a_nerr: assert property (p_nerr) else $error("mapped access refused");
	property p_upper; pready |-> prdata[31:8] == 24'h000000; endproperty
	a_upper: assert property (p_upper) else $error("upper read bits not zero");
	property p_oe; 1'b1 |=> pin_oe_n_q == !$past(port_dir_out); endproperty
	a_oe: assert property (p_oe) else $error("pin not driven for output direction");
	property p_port; com_q == 2'h0 |=> pin_out_q == $past(port_value); endproperty
	a_port: assert property (p_port) else $error("port value not on pin");
	property p_movf; !msk_q[0] |=> !overflow_irq_q; endproperty
	a_movf: assert property (p_movf) else $error("masked overflow request");
	property p_mcmp; !msk_q[1] |=> !compare_irq_q; endproperty
	a_mcmp: assert property (p_mcmp) else $error("masked compare request");
	property p_ack; irq_ack_compare |-> ##2 !compare_irq_q; endproperty
	a_ack: assert property (p_ack) else $error("compare request survives service");
endmodule : atoc_checker
bind atoc_timer atoc_checker i_atoc_checker (.clk, .rst, .psel, .penable, .pwrite, .paddr,
	.pwdata, .prdata, .pready, .pslverr, .crystal_pin_one, .irq_ack_overflow,
	.irq_ack_compare, .port_value, .port_dir_out, .overflow_irq_q, .compare_irq_q,
	.pin_out_q, .pin_oe_n_q);
`default_nettype wire

/* File: test/atoc_core_model.sv */
// model of the processor side: interrupt service and a free running watch crystal
// assumes requests are levels and each service answers with a one-cycle ack pulse
`timescale 1ns/1ps
`default_nettype none
module atoc_core_model (
	input  wire logic       clk,
	input  wire logic       rst,
	input  wire logic       slow,
	input  wire logic       ack_en,
	input  wire logic [1:0] irq,
	output var  logic [1:0] ack,
	output var  logic [7:0] served,
	output var  logic       crystal
);
	logic [2:0] cnt_q [2];
	// a watch crystal runs free, so no framing of its edges
	initial begin
		crystal = 1'b0;
		#2;
		forever #35 crystal = ~crystal;
	end
	// cooldown after the ack keeps one request from being served twice
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ack <= 2'h0;
			served <= 8'h00;
			for (int i = 0; i < 2; i++) begin
				cnt_q[i] <= 3'h0;
			end
		end else begin
			for (int i = 0; i < 2; i++) begin
				ack[i] <= (cnt_q[i] == 3'h4);
				if (cnt_q[i] != 3'h0) begin
					cnt_q[i] <= cnt_q[i] - 3'h1;
				end else if (irq[i] && ack_en) begin
					cnt_q[i] <= slow ? 3'h7 : 3'h5;
				end
			end
			served <= served + {7'h00, ack[0]} + {7'h00, ack[1]};
		end
	end
endmodule : atoc_core_model
`default_nettype wire

/* File: test/tb.sv */
// self-checking bench for the 8-bit timer with one compare channel
// assumes the core model serves interrupts and supplies the crystal
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic        clk, rst, psel, penable, pwrite, er, oc, slow, ack_en;
	logic [7:0]  paddr, v, c, served;
	logic [31:0] pwdata, prdata, rv;
	logic        pready, pslverr, crystal_pin_one, port_value, port_dir_out;
	logic        irq_ack_overflow, irq_ack_compare, overflow_irq_q, compare_irq_q;
	logic        pin_out_q, pin_oe_n_q;
	logic [1:0]  m;
	int          miscompares, num_checks, seed, hi;
	atoc_timer i_atoc_timer (.clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .crystal_pin_one, .irq_ack_overflow, .irq_ack_compare, .port_value,
		.port_dir_out, .overflow_irq_q, .compare_irq_q, .pin_out_q, .pin_oe_n_q);
	atoc_core_model i_atoc_core_model (.clk, .rst, .slow, .ack_en,
		.irq({compare_irq_q, overflow_irq_q}), .ack({irq_ack_compare, irq_ack_overflow}),
		.served, .crystal(crystal_pin_one));
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	always @(posedge clk) begin
		port_value <= 1'($random(seed));
		port_dir_out <= 1'($random(seed));
	end
	// ----------------------------------------
	// tasks and expectations
	// ----------------------------------------
	task automatic final_report();
		$display("checks %0d mismatches %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : final_report
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 16);
		rv = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 16) begin
			miscompares++;
			final_report();
		end
	endtask : apb
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask : wr
	task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h00000000);
		chk(rv, exp);
	endtask : rdc
	task automatic done(input string s);
		$display("test %s finished", s);
	endtask : done
	function automatic logic [31:0] ctl(input logic [2:0] cs, input logic [1:0] wg,
		input logic [1:0] cm, input logic f);
		return (32'(cs) << atoc_pkg::CTRL_CS_LSB) | (32'(wg) << atoc_pkg::CTRL_WGM_LSB)
			| (32'(cm) << atoc_pkg::CTRL_COM_LSB) | (32'(f) << atoc_pkg::CTRL_FORCE_BIT);
	endfunction : ctl
	function automatic logic pin_next(input logic [1:0] cm, input logic cur);
		case (cm)
			2'h1: return ~cur;
			2'h2: return 1'b0;
			2'h3: return 1'b1;
			default: return cur;
		endcase
	endfunction : pin_next
	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		{rst, psel, penable, pwrite, paddr, pwdata} = {3'h4, 1'b0, 8'h00, 32'h00000000};
		{slow, ack_en, miscompares, num_checks} = '0;
		seed = 86;
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		for (int i = 0; i < 6; i++) begin
			rdc(8'(4 * i), 32'h00000000);
		end
		rdc(8'h18, 32'h00000000);
		chk(32'(er), 32'h00000001);
		done("reset");
		for (int i = 0; i < 4; i++) begin
			v = 8'($random(seed));
			wr(atoc_pkg::ADDR_COUNT, {24'h000000, v});
			repeat (20) @(posedge clk);
			rdc(atoc_pkg::ADDR_COUNT, {24'h000000, v});
		end
		done("stopped");
		c = 8'hF1 + (8'($random(seed)) & 8'h0E);
		wr(atoc_pkg::ADDR_COMPARE, {24'h000000, c});
		wr(atoc_pkg::ADDR_COUNT, 32'h000000F0);
		wr(atoc_pkg::ADDR_CONTROL, ctl(3'h1, atoc_pkg::ATOC_WGM_NORMAL, 2'h0, 1'b0));
		repeat (40) @(posedge clk);
		rdc(atoc_pkg::ADDR_FLAGS, 32'h00000003);
		wr(atoc_pkg::ADDR_FLAGS, 32'h00000001);
		rdc(atoc_pkg::ADDR_FLAGS, 32'h00000002);
		wr(atoc_pkg::ADDR_FLAGS, 32'h00000002);
		rdc(atoc_pkg::ADDR_FLAGS, 32'h00000000);
		done("normal");
		slow <= 1'($random(seed));
		ack_en <= 1'b1;
		wr(atoc_pkg::ADDR_MASK, 32'h00000003);
		repeat (600) @(posedge clk);
		chk(32'(served >= 8'h03), 32'h00000001);
		ack_en <= 1'b0;
		wr(atoc_pkg::ADDR_MASK, 32'h00000000);
		wr(atoc_pkg::ADDR_CONTROL, 32'h00000000);
		wr(atoc_pkg::ADDR_FLAGS, 32'h00000003);
		done("service");
		c = 8'($random(seed)) & 8'h7F;
		wr(atoc_pkg::ADDR_COMPARE, {24'h000000, c});
		wr(atoc_pkg::ADDR_COUNT, {24'h000000, c});
		wr(atoc_pkg::ADDR_CONTROL, ctl(3'h1, atoc_pkg::ATOC_WGM_NORMAL, 2'h0, 1'b0));
		repeat (20) @(posedge clk);
		rdc(atoc_pkg::ADDR_FLAGS, 32'h00000000);
		wr(atoc_pkg::ADDR_CONTROL, 32'h00000000);
		done("block");
		wr(atoc_pkg::ADDR_COUNT, 32'h00000000);
		wr(atoc_pkg::ADDR_COMPARE, 32'h00000009);
		wr(atoc_pkg::ADDR_CONTROL, ctl(3'h1, atoc_pkg::ATOC_WGM_CTC, 2'h0, 1'b0));
		for (int i = 0; i < 8; i++) begin
			apb(1'b0, atoc_pkg::ADDR_COUNT, 32'h00000000);
			chk(32'(rv <= 32'h00000009), 32'h00000001);
		end
		rdc(atoc_pkg::ADDR_FLAGS, 32'h00000002);
		wr(atoc_pkg::ADDR_CONTROL, 32'h00000000);
		wr(atoc_pkg::ADDR_FLAGS, 32'h00000003);
		done("clear on match");
		oc = 1'b0;
		wr(atoc_pkg::ADDR_COUNT, 32'h00000055);
		for (int i = 0; i < 5; i++) begin
			m = 2'(i % 3 + 1);
			wr(atoc_pkg::ADDR_CONTROL, ctl(3'h0, atoc_pkg::ATOC_WGM_NORMAL, m, 1'b1));
			oc = pin_next(m, oc);
			repeat (4) @(posedge clk);
			chk(32'(pin_out_q), 32'(oc));
		end
		rdc(atoc_pkg::ADDR_CONTROL, ctl(3'h0, atoc_pkg::ATOC_WGM_NORMAL, m, 1'b0));
		rdc(atoc_pkg::ADDR_FLAGS, 32'h00000000);
		rdc(atoc_pkg::ADDR_COUNT, 32'h00000055);
		wr(atoc_pkg::ADDR_CONTROL, ctl(3'h0, atoc_pkg::ATOC_WGM_FAST, 2'h1, 1'b1));
		repeat (4) @(posedge clk);
		chk(32'(pin_out_q), 32'(oc));
		wr(atoc_pkg::ADDR_CONTROL, ctl(3'h0, atoc_pkg::ATOC_WGM_NORMAL, 2'h0, 1'b1));
		wr(atoc_pkg::ADDR_CONTROL, ctl(3'h0, atoc_pkg::ATOC_WGM_NORMAL, 2'h1, 1'b0));
		repeat (4) @(posedge clk);
		chk(32'(pin_out_q), 32'(oc));
		done("force");
		wr(atoc_pkg::ADDR_COUNT, 32'h00000000);
		wr(atoc_pkg::ADDR_CONTROL, ctl(3'h0, atoc_pkg::ATOC_WGM_FAST, 2'h2, 1'b0));
		wr(atoc_pkg::ADDR_COMPARE, 32'h00000040);
		rdc(atoc_pkg::ADDR_COMPARE, 32'h00000040);
		wr(atoc_pkg::ADDR_CONTROL, ctl(3'h1, atoc_pkg::ATOC_WGM_FAST, 2'h2, 1'b0));
		repeat (300) @(posedge clk);
		hi = 0;
		repeat (512) begin
			@(posedge clk);
			hi += int'(pin_out_q);
		end
		chk(32'(hi >= 2 * 65 - 10 && hi <= 2 * 65 + 10), 32'h00000001);
		wr(atoc_pkg::ADDR_CONTROL, 32'h00000000);
		done("pwm");
		wr(atoc_pkg::ADDR_ASYNC, 32'h00000001);
		wr(atoc_pkg::ADDR_COUNT, 32'h00000000);
		wr(atoc_pkg::ADDR_CONTROL, ctl(3'h1, atoc_pkg::ATOC_WGM_NORMAL, 2'h0, 1'b0));
		repeat (200) @(posedge clk);
		wr(atoc_pkg::ADDR_CONTROL, 32'h00000000);
		apb(1'b0, atoc_pkg::ADDR_COUNT, 32'h00000000);
		chk(32'(rv >= 32'h00000014 && rv <= 32'h00000028), 32'h00000001);
		rdc(atoc_pkg::ADDR_ASYNC, 32'h00000001);
		wr(atoc_pkg::ADDR_ASYNC, 32'h00000000);
		done("crystal");
		final_report();
	end
endmodule : tb
`default_nettype wire
